// >>> inc/obl_consts.svh
// Constants for the boot image loader: layout offsets, markers and timing counts.
`ifndef OBL_CONSTS_SVH
`define OBL_CONSTS_SVH
`define OBL_OTP_WORDS 8192
`define OBL_OTP_AW 13
`define OBL_VEC_BASE 13'h0000
`define OBL_VEC_WORDS 64
`define OBL_HDR_WORDS 64
`define OBL_HDR_BASE_BYTE 16'h7f00
`define OBL_APP_FLAG1_BYTE 16'h7f00
`define OBL_LEN_BYTE 16'h7ff8
`define OBL_DBG_BYTE 16'h7ffc
`define OBL_APP_MARKER 32'h1234a5a5
`define OBL_DBG_ON 8'h00
`define OBL_DBG_OFF 8'haa
`define OBL_RD_LAT 2
`endif

// >>> inc/obl_pkg.sv
// Types shared by the boot image loader files.
package obl_pkg;
    typedef enum logic [1:0] {
        OBL_MODE_NORMAL,
        OBL_MODE_DEVEL,
        OBL_MODE_CALIB
    } obl_mode_t;
    typedef enum logic [1:0] {
        OBL_REMAP_ROM,
        OBL_REMAP_SRAM,
        OBL_REMAP_RET
    } obl_remap_t;
    typedef struct packed {
        logic [12:0] addr;
        logic [31:0] data;
    } obl_word_t;
    typedef struct packed {
        logic done;
        logic app_present;
        logic dbg_enable;
        logic [12:0] length;
    } obl_status_t;
endpackage

// >>> logic/obl_fifo.sv
// Parameterised word FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module obl_fifo #(
    parameter int WIDTH = 45,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wp_next = '0;
            rp_next = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rp_reg];

    // The loader offers each word for one cycle only, so a word offered while full would be lost.
    chk_fifo_no_overflow: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
        cnt_reg == (AW+1)'(DEPTH) |-> !in_valid) else $error("fifo offered a word while full");
endmodule // obl_fifo

// >>> logic/obl_loader.sv
// Boot image loader: copies the program image from the OTP array into system SRAM.
//
// Summary of operation
// (R1) The loader addresses an OTP array of 8192 words of 32 bits each.
// (R2) The image starts with a 64-word interrupt vector list at address zero, copied as part of the image.
// (R3) The top 64 words of the array are a configuration header read by the loader and boot code.
// (R4) The programmer leaves one blank word between customer code and the first patch area.
// (R5) Each patch area is a header plus payload, stacked above the customer code.
// (R6) In normal mode every boot or wake-up copies the image into SRAM with no software help; the loader skips the copy without the app marker.
// (R7) After the copy, control passes to SRAM by a software reset or a jump request.
// (R8) The copy runs while the fast RC oscillator clocks the block and the main crystal settles.
// (R9) In development mode address zero is remapped onto the memory holding the downloaded code and the core resets.
// (R10) The product maker programs the device address and the crystal trim into header fields.
// (R11) The header length word gives the number of 32-bit words to copy.
// (R12) The top header word enables the debug port when zero and disables it when 0xaa.
// (R13) An application is present only when the first application flag word holds its marker.
// (R14) The core is held out of SRAM until the full count is copied, then done is raised; with no application marker the core is released with nothing copied.
`timescale 1ns/1ns
`include "obl_consts.svh"
module obl_loader import obl_pkg::*; #(
    parameter int AW = `OBL_OTP_AW,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic boot_req,
    input wire obl_mode_t mode,
    input wire obl_remap_t devel_target,
    input wire logic use_jump,
    input wire logic fast_rc_oscillator_on,
    input wire logic main_crystal_oscillator_ready,
    output logic otp_rd_en,
    output logic [AW-1:0] otp_addr,
    input wire logic [31:0] otp_rdata,
    output logic sram_we,
    output logic [AW-1:0] sram_addr,
    output logic [31:0] sram_wdata,
    input wire logic sram_ready,
    output logic cpu_hold,
    output logic sw_reset,
    output logic jump_sram,
    output obl_remap_t remap_sel,
    output obl_status_t status,
    output logic copy_clk_sel_rc
);
    typedef enum logic [2:0] {
        OBL_IDLE, OBL_RD_DBG, OBL_RD_LEN, OBL_RD_FLAG, OBL_COPY, OBL_DRAIN, OBL_HANDOFF
    } obl_state_t;

    function automatic logic [AW-1:0] byte_to_word(input logic [15:0] b);
        byte_to_word = b[AW+1:2];
    endfunction

    obl_state_t st_reg, st_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
    logic [AW:0] len_reg, len_next;
    logic [1:0] lat_reg, lat_next;
    logic rd_en_reg, rd_en_next, pend_reg, pend_next;
    logic [AW-1:0] pend_addr_reg, pend_addr_next;
    logic dbg_reg, dbg_next, app_reg, app_next, done_reg, done_next;
    logic hold_reg, hold_next, swr_reg, swr_next, jmp_reg, jmp_next, clk_rc_reg, clk_rc_next;
    logic we_reg, we_next;
    logic [AW-1:0] sa_reg, sa_next;
    logic [31:0] sd_reg, sd_next;
    obl_remap_t remap_reg, remap_next;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    obl_word_t f_in, f_out;

    obl_fifo #(.WIDTH($bits(obl_word_t)), .DEPTH(FIFO_DEPTH)) obl_fifo_inst (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .flush(st_reg == OBL_IDLE),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    // Read data returns one cycle after the strobe; only one read is in flight so the FIFO never overruns.
    always_comb begin
        f_in.addr = pend_addr_reg;
        f_in.data = otp_rdata;
        f_in_valid = pend_reg && (st_reg == OBL_COPY || st_reg == OBL_DRAIN);
        f_out_ready = !we_reg || sram_ready;
    end

    always_comb begin
        st_next = st_reg;
        rd_ptr_next = rd_ptr_reg;
        wr_ptr_next = wr_ptr_reg;
        len_next = len_reg;
        lat_next = lat_reg;
        rd_en_next = 1'b0;
        pend_next = rd_en_reg;
        pend_addr_next = otp_addr;
        dbg_next = dbg_reg;
        app_next = app_reg;
        done_next = done_reg;
        hold_next = hold_reg;
        swr_next = 1'b0;
        jmp_next = 1'b0;
        clk_rc_next = clk_rc_reg;
        remap_next = remap_reg;
        we_next = we_reg && !sram_ready;
        sa_next = sa_reg;
        sd_next = sd_reg;
        if (f_out_valid && f_out_ready) begin
            we_next = 1'b1;
            sa_next = f_out.addr;
            sd_next = f_out.data;
            wr_ptr_next = wr_ptr_reg + 1'b1;
        end
        case (st_reg)
            OBL_IDLE: begin
                if (boot_req) begin
                    hold_next = 1'b1; // R14
                    done_next = 1'b0;
                    wr_ptr_next = '0;
                    if (mode == OBL_MODE_DEVEL) begin
                        remap_next = devel_target; // R9
                        swr_next = 1'b1; // R9
                        // Nothing is copied, so the core is let go at once to restart from the remapped memory.
                        hold_next = 1'b0; // R9
                        done_next = 1'b1; // R9
                    end else begin
                        remap_next = OBL_REMAP_SRAM;
                        clk_rc_next = !main_crystal_oscillator_ready && fast_rc_oscillator_on; // R8
                        rd_en_next = 1'b1;
                        pend_addr_next = byte_to_word(`OBL_DBG_BYTE); // R3 R12
                        lat_next = '0;
                        st_next = OBL_RD_DBG;
                    end
                end
            end
            OBL_RD_DBG: begin
                lat_next = lat_reg + 1'b1;
                if (lat_reg == 2'(`OBL_RD_LAT - 1)) begin
                    dbg_next = (otp_rdata[7:0] != `OBL_DBG_OFF); // R12
                    rd_en_next = 1'b1;
                    pend_addr_next = byte_to_word(`OBL_LEN_BYTE);
                    lat_next = '0;
                    st_next = OBL_RD_LEN;
                end
            end
            OBL_RD_LEN: begin
                lat_next = lat_reg + 1'b1;
                if (lat_reg == 2'(`OBL_RD_LAT - 1)) begin
                    // Clip the count so the copy never walks into the header.
                    len_next = (otp_rdata > 32'(`OBL_OTP_WORDS - `OBL_HDR_WORDS)) ?
                        (AW+1)'(`OBL_OTP_WORDS - `OBL_HDR_WORDS) : otp_rdata[AW:0]; // R11 R1
                    rd_en_next = 1'b1;
                    pend_addr_next = byte_to_word(`OBL_APP_FLAG1_BYTE);
                    lat_next = '0;
                    st_next = OBL_RD_FLAG;
                end
            end
            OBL_RD_FLAG: begin
                lat_next = lat_reg + 1'b1;
                if (lat_reg == 2'(`OBL_RD_LAT - 1)) begin
                    app_next = (otp_rdata == `OBL_APP_MARKER); // R13
                    rd_ptr_next = `OBL_VEC_BASE; // R2
                    st_next = (otp_rdata == `OBL_APP_MARKER) ? OBL_COPY : OBL_HANDOFF;
                end
            end
            OBL_COPY: begin
                if ({1'b0, rd_ptr_reg} == len_reg || rd_ptr_reg == AW'(`OBL_OTP_WORDS - 1)) begin
                    st_next = OBL_DRAIN;
                end else if (!rd_en_reg && !pend_reg && f_in_ready) begin
                    // Patch areas sit inside the counted length above the customer code, so they copy like any word.
                    rd_en_next = 1'b1; // R6 R5
                    pend_addr_next = rd_ptr_reg;
                    rd_ptr_next = rd_ptr_reg + 1'b1;
                end
            end
            OBL_DRAIN: begin
                if ((AW+1)'(wr_ptr_next) == len_reg && !f_out_valid && !rd_en_reg && !pend_reg
                    && !we_next) begin
                    st_next = OBL_HANDOFF;
                end
            end
            OBL_HANDOFF: begin
                done_next = 1'b1; // R14
                hold_next = 1'b0; // R14
                clk_rc_next = 1'b0;
                if (use_jump) begin
                    jmp_next = app_reg; // R7
                end else begin
                    swr_next = app_reg; // R7
                end
                st_next = OBL_IDLE;
            end
            default: st_next = OBL_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= OBL_IDLE;
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            len_reg <= '0;
            lat_reg <= '0;
            rd_en_reg <= 1'b0;
            pend_reg <= 1'b0;
            pend_addr_reg <= '0;
            dbg_reg <= 1'b1;
            app_reg <= 1'b0;
            done_reg <= 1'b0;
            hold_reg <= 1'b1;
            swr_reg <= 1'b0;
            jmp_reg <= 1'b0;
            clk_rc_reg <= 1'b0;
            remap_reg <= OBL_REMAP_ROM;
            we_reg <= 1'b0;
            sa_reg <= '0;
            sd_reg <= '0;
        end else begin
            st_reg <= st_next;
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            len_reg <= len_next;
            lat_reg <= lat_next;
            rd_en_reg <= rd_en_next;
            pend_reg <= pend_next;
            pend_addr_reg <= pend_addr_next;
            dbg_reg <= dbg_next;
            app_reg <= app_next;
            done_reg <= done_next;
            hold_reg <= hold_next;
            swr_reg <= swr_next;
            jmp_reg <= jmp_next;
            clk_rc_reg <= clk_rc_next;
            remap_reg <= remap_next;
            we_reg <= we_next;
            sa_reg <= sa_next;
            sd_reg <= sd_next;
        end
    end

    assign otp_rd_en = rd_en_reg;
    assign otp_addr = pend_addr_reg;
    assign sram_we = we_reg;
    assign sram_addr = sa_reg;
    assign sram_wdata = sd_reg;
    assign cpu_hold = hold_reg;
    assign sw_reset = swr_reg;
    assign jump_sram = jmp_reg;
    assign remap_sel = remap_reg;
    assign copy_clk_sel_rc = clk_rc_reg;
    assign status = '{done: done_reg, app_present: app_reg, dbg_enable: dbg_reg, length: len_reg[AW-1:0]};

    // Read data one cycle late, so the decode checks can compare against what the header read returned.
    logic [31:0] otp_rdata_q;
    always_ff @(posedge ref_clk) begin
        otp_rdata_q <= otp_rdata;
    end

    chk_hold_until_done: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
        !hold_reg |-> done_reg || st_reg == OBL_IDLE) else $error("core released before copy done");
    chk_handoff_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
        (jmp_reg || (swr_reg && remap_reg == OBL_REMAP_SRAM)) |-> done_reg && !hold_reg)
        else $error("handoff without done");
    chk_dbg_decode: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
        st_reg == OBL_RD_DBG && lat_reg == 2'(`OBL_RD_LAT - 1) |=> dbg_reg == (otp_rdata_q[7:0] != `OBL_DBG_OFF))
        else $error("debug flag decode wrong");
    chk_app_marker: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
        st_reg == OBL_RD_FLAG && lat_reg == 2'(`OBL_RD_LAT - 1) |=> app_reg == (otp_rdata_q == `OBL_APP_MARKER))
        else $error("app marker decode wrong");
    chk_sram_range: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
        we_reg |-> {1'b0, sa_reg} < len_reg) else $error("write beyond length");
    chk_copy_needs_app: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
        st_reg == OBL_COPY |-> app_reg) else $error("copy without application");
    chk_devel_remap: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
        st_reg == OBL_IDLE && boot_req && mode == OBL_MODE_DEVEL |=> sw_reset && remap_reg == $past(devel_target))
        else $error("devel remap missing");
    chk_rc_clock: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
        st_reg == OBL_IDLE && boot_req && mode != OBL_MODE_DEVEL && !main_crystal_oscillator_ready
        && fast_rc_oscillator_on |=> clk_rc_reg) else $error("rc clock not selected");
endmodule // obl_loader

// >>> bench/obl_mem_model.sv
// Behavioural OTP array and SRAM write port facing the boot image loader.
`timescale 1ns/1ns
module obl_mem_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic otp_rd_en,
    input wire logic [12:0] otp_addr,
    output logic [31:0] otp_rdata,
    input wire logic sram_we,
    input wire logic [12:0] sram_addr,
    input wire logic [31:0] sram_wdata,
    output logic sram_ready
);
    // The bench loads the whole 8K image, vectors and header before each boot.
    logic [31:0] otp_mem [0:8191];
    logic [31:0] sram_mem [0:8191];
    logic [2:0] stall_cnt = 3'h0;
    // Read data appears one cycle after the strobe and holds until the next one.
    always @(posedge ref_clk) begin
        stall_cnt <= stall_cnt + 3'h1;
        if (otp_rd_en) begin
            otp_rdata <= otp_mem[otp_addr];
        end
        if (sram_we && sram_ready) begin
            sram_mem[sram_addr] <= sram_wdata;
        end
    end
    // A slow SRAM takes one word in eight, slower than reads arrive, so the loader's FIFO fills and refuses.
    assign sram_ready = !slow || (stall_cnt == 3'h0);
endmodule // obl_mem_model

// >>> bench/obl_loader_tb.sv
// Self-checking testbench for the boot image loader.
`timescale 1ns/1ns
`include "obl_consts.svh"
module obl_loader_tb import obl_pkg::*; ;
    logic ref_clk, nrst, boot_req, use_jump, rc_on, xtal_rdy, slow, otp_rd_en, sram_we, sram_ready;
    logic cpu_hold, sw_reset, jump_sram, copy_clk_sel_rc, hold_bad;
    obl_mode_t mode;
    obl_remap_t devel_target, remap_sel;
    obl_status_t status;
    logic [12:0] otp_addr, sram_addr;
    logic [31:0] otp_rdata, sram_wdata;
    logic [12:0] rd_log [0:2];
    int num_errors = 0, tests_run = 0, n_sw, n_jmp, n_wr, n_rc, n_rd, pulse_wr;

    obl_loader #(.AW(13), .FIFO_DEPTH(16)) obl_loader_inst (.ref_clk(ref_clk), .nrst(nrst), .boot_req(boot_req),
        .mode(mode), .devel_target(devel_target), .use_jump(use_jump), .fast_rc_oscillator_on(rc_on),
        .main_crystal_oscillator_ready(xtal_rdy), .otp_rd_en(otp_rd_en), .otp_addr(otp_addr),
        .otp_rdata(otp_rdata), .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_ready(sram_ready), .cpu_hold(cpu_hold), .sw_reset(sw_reset), .jump_sram(jump_sram),
        .remap_sel(remap_sel), .status(status), .copy_clk_sel_rc(copy_clk_sel_rc));
    obl_mem_model obl_mem_model_inst (.ref_clk(ref_clk), .slow(slow), .otp_rd_en(otp_rd_en), .otp_addr(otp_addr),
        .otp_rdata(otp_rdata), .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_ready(sram_ready));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Counts accepted writes and handoff pulses so each scenario can judge the whole boot.
    always @(posedge ref_clk) begin
        if (sram_we === 1'b1 && sram_ready === 1'b1) begin
            n_wr <= n_wr + 1;
            if (cpu_hold !== 1'b1) hold_bad <= 1'b1;
            if (copy_clk_sel_rc === 1'b1) n_rc <= n_rc + 1;
        end
        if (otp_rd_en === 1'b1) begin
            if (n_rd < 3) rd_log[n_rd] <= otp_addr;
            n_rd <= n_rd + 1;
        end
        if (sw_reset === 1'b1) n_sw <= n_sw + 1;
        if (jump_sram === 1'b1) n_jmp <= n_jmp + 1;
        if (sw_reset === 1'b1 || jump_sram === 1'b1) pulse_wr <= n_wr;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic run_boot(input obl_mode_t m, input logic jmp, input logic [12:0] len, input logic [31:0] flag,
                            input logic [7:0] dbg, input logic sl, input logic xr);
        int i;
        for (i = 0; i < 8192; i++) begin
            obl_mem_model_inst.otp_mem[i] = 32'h5ec0_0000 ^ i;
            obl_mem_model_inst.sram_mem[i] = 32'hdead_beef;
        end
        obl_mem_model_inst.otp_mem[`OBL_LEN_BYTE >> 2] = {19'h0, len};
        obl_mem_model_inst.otp_mem[`OBL_DBG_BYTE >> 2] = {4{dbg}};
        obl_mem_model_inst.otp_mem[`OBL_APP_FLAG1_BYTE >> 2] = flag;
        // The image carries a blank word, then a patch header and its payload.
        obl_mem_model_inst.otp_mem[30] = 32'h0;
        obl_mem_model_inst.otp_mem[31] = 32'h0000_0a11;
        obl_mem_model_inst.otp_mem[16'h7fd4 >> 2] = 32'h0102_0304;
        obl_mem_model_inst.otp_mem[16'h7f8c >> 2] = 32'h0000_0155;
        @(posedge ref_clk);
        mode <= m;
        use_jump <= jmp;
        slow <= sl;
        xtal_rdy <= xr;
        n_wr <= 0;
        n_rc <= 0;
        n_rd <= 0;
        n_sw <= 0;
        n_jmp <= 0;
        pulse_wr <= -1;
        hold_bad <= 1'b0;
        boot_req <= 1'b1;
        @(posedge ref_clk);
        boot_req <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 40000 && !(status.done === 1'b1 || n_sw > 0 || n_jmp > 0); i++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic check_copy(input int len, input logic jmp, input logic dbg_exp);
        int i;
        check(rd_log[0], `OBL_DBG_BYTE >> 2);
        check(rd_log[1], `OBL_LEN_BYTE >> 2);
        check(rd_log[2], `OBL_APP_FLAG1_BYTE >> 2);
        check(status.done, 1'b1);
        check(status.app_present, 1'b1);
        check(status.dbg_enable, dbg_exp);
        check(status.length, len);
        check(n_wr, len);
        check(pulse_wr, len);
        check(n_sw, !jmp);
        check(n_jmp, jmp);
        check(hold_bad, 1'b0);
        check(cpu_hold, 1'b0);
        for (i = 0; i < len; i++) check(obl_mem_model_inst.sram_mem[i], obl_mem_model_inst.otp_mem[i]);
        check(obl_mem_model_inst.sram_mem[len], 32'hdead_beef);
    endtask

    task automatic t_reset;
        check(cpu_hold, 1'b1);
        check(status, {1'b0, 1'b0, 1'b1, 13'h0000});
        check(remap_sel, OBL_REMAP_ROM);
        check({sw_reset, jump_sram, sram_we, otp_rd_en}, 4'h0);
    endtask

    task automatic t_normal;
        run_boot(OBL_MODE_NORMAL, 1'b0, 13'h0005, `OBL_APP_MARKER, `OBL_DBG_OFF, 1'b0, 1'b1);
        check_copy(5, 1'b0, 1'b0);
        check(n_rc, 0);
    endtask

    // Slow SRAM with the crystal still settling: the whole copy must run on the RC clock.
    task automatic t_stall_jump;
        run_boot(OBL_MODE_CALIB, 1'b1, 13'h0028, `OBL_APP_MARKER, `OBL_DBG_ON, 1'b1, 1'b0);
        check_copy(40, 1'b1, 1'b1);
        check(n_rc, 40);
    endtask

    // Crystal not ready but the RC oscillator off: the copy must not claim the RC clock.
    task automatic t_clip;
        rc_on <= 1'b0;
        run_boot(OBL_MODE_NORMAL, 1'b0, 13'h1fff, `OBL_APP_MARKER, `OBL_DBG_OFF, 1'b0, 1'b0);
        check_copy(8192 - `OBL_HDR_WORDS, 1'b0, 1'b0);
        check(n_rc, 0);
    endtask

    task automatic t_noapp;
        run_boot(OBL_MODE_NORMAL, 1'b0, 13'h0005, ~`OBL_APP_MARKER, `OBL_DBG_OFF, 1'b0, 1'b1);
        check(status.done, 1'b1);
        check(status.app_present, 1'b0);
        check(n_wr, 0);
        check(n_sw + n_jmp, 0);
    endtask

    task automatic t_devel(input obl_remap_t tgt);
        @(posedge ref_clk);
        devel_target <= tgt;
        run_boot(OBL_MODE_DEVEL, 1'b0, 13'h0005, `OBL_APP_MARKER, `OBL_DBG_OFF, 1'b0, 1'b1);
        check(remap_sel, tgt);
        check(n_sw, 1);
        check(n_wr, 0);
        check(cpu_hold, 1'b0);
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        boot_req = 1'b0;
        mode = OBL_MODE_NORMAL;
        devel_target = OBL_REMAP_ROM;
        use_jump = 1'b0;
        rc_on = 1'b1;
        xtal_rdy = 1'b1;
        slow = 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset();
        nrst <= 1'b1;
        t_normal();
        t_stall_jump();
        t_noapp();
        t_devel(OBL_REMAP_SRAM);
        t_devel(OBL_REMAP_RET);
        t_clip();
        finish_test();
    end
endmodule // obl_loader_tb
